// >>> pkg/bram_pkg.sv
// Constants, encodings and helpers for the embedded block RAM tile.
// Assumes one clock domain and user logic in the fabric on both ports.
// Behaviour
// RULE1 - The tile holds 18 Kb of storage usable as single-port, true dual-port, pseudo dual-port RAM or ROM.
// RULE2 - Input and output register stages of each port have their own enables.
// RULE3 - Shapes run from 16,384 x 1 to 512 x 36, with true dual-port limited to 1,024 x 18.
// RULE4 - Any FIFO pointers and flags live in user logic; the tile only stores the data.
// RULE5 - Every stored byte carries an optional ninth parity bit.
// RULE6 - Per-byte write enables apply at the 18-bit and 36-bit widths.
// RULE7 - In the multi-port modes each port may use its own width over the same array.
// RULE8 - Bits map linearly from the low bit of word zero upward, identically on every port.
// RULE9 - Contents may be preloaded before user operation starts.
// RULE10 - With preloaded contents and writes disabled the tile acts as a ROM.
// RULE11 - Address, data and write controls are registered at the array input.
// RULE12 - Read data either comes straight from the array stage or through an extra output register.
// RULE13 - Normal write mode leaves the output unchanged during a write and updates it on reads.
// RULE14 - Write-through mode shows the written data on the same port during a write.
// RULE15 - Read-before-write shows the old word during a write, only at x9, x18 and x36.
// RULE16 - User logic must not write the same address from both ports in one cycle.

package bram_pkg;

  localparam int unsigned MEM_BITS   = 18432;
  localparam int unsigned ADDR_W     = 14;
  localparam int unsigned DATA_W     = 36;
  localparam int unsigned UNIT_W     = 9;
  localparam int unsigned LD_ADDR_W  = 11;
  localparam logic [13:0] ADDR_FULL  = 14'h3FFF;
  localparam logic [35:0] DATA_FULL  = 36'hFFFFFFFFF;
  localparam logic [35:0] DOUT_RST   = 36'h000000000;

  typedef enum logic [1:0] {
    MODE_SP  = 2'b00,
    MODE_TDP = 2'b01,
    MODE_PDP = 2'b10,
    MODE_ROM = 2'b11
  } bram_mode_e;

  typedef enum logic [2:0] {
    WID_1  = 3'b000,
    WID_2  = 3'b001,
    WID_4  = 3'b010,
    WID_9  = 3'b011,
    WID_18 = 3'b100,
    WID_36 = 3'b101
  } bram_wid_e;

  typedef enum logic [1:0] {
    WM_NORMAL = 2'b00,
    WM_THRU   = 2'b01,
    WM_RBW    = 2'b10
  } bram_wmode_e;

  // Bits per word for a width code, zero when illegal
  function automatic logic [5:0] width_bits(logic [2:0] w);
    case (w)
      3'h0:    width_bits = 6'h01;
      3'h1:    width_bits = 6'h02;
      3'h2:    width_bits = 6'h04;
      3'h3:    width_bits = 6'h09;
      3'h4:    width_bits = 6'h12;
      3'h5:    width_bits = 6'h24;
      default: width_bits = 6'h00;
    endcase
  endfunction : width_bits

endpackage : bram_pkg

// >>> design/bram_core.sv
// Embedded block RAM tile: storage array, two ports, preload port.
// Assumes synchronous inputs on one clock and user logic obeying the collision limit.
`timescale 1ns/10ps
`default_nettype none

module bram_core (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Configuration
  input  wire logic [1:0]  mode,
  input  wire logic [2:0]  a_width,
  input  wire logic [2:0]  b_width,
  input  wire logic [1:0]  a_wmode,
  input  wire logic [1:0]  b_wmode,
  input  wire logic        a_oreg,
  input  wire logic        b_oreg,
  input  wire logic        user_start,
  // Preload
  input  wire logic        ld_en,
  input  wire logic [10:0] ld_addr,
  input  wire logic [8:0]  ld_data,
  // Port A
  input  wire logic        a_ce,
  input  wire logic        a_oce,
  input  wire logic        a_we,
  input  wire logic [3:0]  a_be,
  input  wire logic [13:0] a_addr,
  input  wire logic [35:0] a_wdata,
  output logic      [35:0] a_rdata,
  // Port B
  input  wire logic        b_ce,
  input  wire logic        b_oce,
  input  wire logic        b_we,
  input  wire logic [3:0]  b_be,
  input  wire logic [13:0] b_addr,
  input  wire logic [35:0] b_wdata,
  output logic      [35:0] b_rdata,
  // Status
  output logic             user_run,
  output logic             cfg_err
);

  // Storage: 2048 units of 8 data bits plus parity, flat bit array
  logic mem [0:bram_pkg::MEM_BITS-1]; // RULE1 RULE5

  // Per-port views
  logic [2:0]  pw      [2];
  logic [1:0]  pwm     [2];
  logic [5:0]  pbits   [2];
  logic        pce     [2];
  logic        poce    [2];
  logic        poreg   [2];
  logic        pwe     [2];
  logic [3:0]  pbe     [2];
  logic [13:0] paddr   [2];
  logic [35:0] pwd     [2];
  logic        active  [2];
  logic        wr_ok   [2];
  logic        legal   [2];
  logic        rbw_bad [2];
  logic [1:0]  wm_eff  [2];
  logic [35:0] rd_word [2];
  logic [35:0] arr_d   [2];
  logic [35:0] dout_d  [2];
  logic        wr_go   [2];

  // Registers
  logic        req_q   [2];
  logic        we_q    [2];
  logic [3:0]  be_q    [2];
  logic [13:0] addr_q  [2];
  logic [35:0] wd_q    [2];
  logic [35:0] arr_q   [2];
  logic [35:0] dout_q  [2];
  logic        run_q;
  logic        err_q;

  wire logic is_tdp = (mode == bram_pkg::MODE_TDP);
  wire logic is_pdp = (mode == bram_pkg::MODE_PDP);
  wire logic is_rom = (mode == bram_pkg::MODE_ROM);
  wire logic ld_go  = ld_en && !run_q;

  assign pw[0]    = a_width;
  assign pw[1]    = b_width;
  assign pwm[0]   = a_wmode;
  assign pwm[1]   = b_wmode;
  assign pce[0]   = a_ce;
  assign pce[1]   = b_ce;
  assign poce[0]  = a_oce;
  assign poce[1]  = b_oce;
  assign poreg[0] = a_oreg;
  assign poreg[1] = b_oreg;
  assign pwe[0]   = a_we;
  assign pwe[1]   = b_we;
  assign pbe[0]   = a_be;
  assign pbe[1]   = b_be;
  assign paddr[0] = a_addr;
  assign paddr[1] = b_addr;
  assign pwd[0]   = a_wdata;
  assign pwd[1]   = b_wdata;

  // Port roles per mode
  assign active[0] = 1'b1;
  assign active[1] = is_tdp || is_pdp;
  assign wr_ok[0]  = !is_rom; // RULE10
  assign wr_ok[1]  = is_tdp;

  // Linear bit address: data bits skip the parity slot at narrow widths
  function automatic logic [14:0] phys(logic [2:0] w, logic [13:0] a, logic [5:0] i);
    logic [19:0] k;
    k = 20'(a & (bram_pkg::ADDR_FULL >> w)) * 20'(bram_pkg::width_bits(w)) + 20'(i);
    if (w <= bram_pkg::WID_4) begin
      phys = 15'(k[13:3]) * 15'd9 + 15'(k[2:0]);
    end else begin
      phys = k[14:0];
    end
  endfunction : phys

  genvar p, b;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign pbits[p]   = bram_pkg::width_bits(pw[p]);
      assign legal[p]   = active[p] && (pbits[p] != 6'h00) && !(is_tdp && pw[p] == bram_pkg::WID_36); // RULE3 RULE7
      assign rbw_bad[p] = (pwm[p] == bram_pkg::WM_RBW) && (pw[p] < bram_pkg::WID_9);
      assign wm_eff[p]  = rbw_bad[p] ? bram_pkg::WM_NORMAL : pwm[p]; // RULE15
      assign wr_go[p]   = req_q[p] && we_q[p];
      for (b = 0; b < 36; b++) begin : g_bit
        assign rd_word[p][b] = (6'(b) < pbits[p]) ? mem[phys(pw[p], addr_q[p], 6'(b))] : 1'b0; // RULE8
      end
      // Array stage result
      assign arr_d[p] = !req_q[p] ? arr_q[p] :
                        !we_q[p] ? rd_word[p] :
                        (wm_eff[p] == bram_pkg::WM_THRU) ? (wd_q[p] & (bram_pkg::DATA_FULL >> (6'd36 - pbits[p]))) :
                        (wm_eff[p] == bram_pkg::WM_RBW) ? rd_word[p] : arr_q[p]; // RULE13 RULE14 RULE15
      assign dout_d[p] = poreg[p] ? (poce[p] ? arr_q[p] : dout_q[p]) : arr_d[p]; // RULE12 RULE2

      // Input register stage
      always_ff @(posedge clock) begin
        if (!rstn) begin
          req_q[p]  <= 1'b0;
          we_q[p]   <= 1'b0;
          be_q[p]   <= 4'h0;
          addr_q[p] <= 14'h0000;
          wd_q[p]   <= 36'h000000000;
        end else begin
          req_q[p] <= pce[p] && run_q && legal[p]; // RULE2 RULE11
          if (pce[p]) begin
            we_q[p]   <= pwe[p] && wr_ok[p];
            be_q[p]   <= pbe[p];
            addr_q[p] <= paddr[p];
            wd_q[p]   <= pwd[p]; // RULE11
          end
        end
      end

      // Array and output register stages
      always_ff @(posedge clock) begin
        if (!rstn) begin
          arr_q[p]  <= bram_pkg::DOUT_RST;
          dout_q[p] <= bram_pkg::DOUT_RST;
        end else begin
          arr_q[p]  <= arr_d[p];
          dout_q[p] <= dout_d[p];
        end
      end
    end
  endgenerate

  // Array writes; port B wins a same-address collision
  always_ff @(posedge clock) begin
    if (ld_go) begin
      for (int j = 0; j < 9; j++) begin
        mem[15'(ld_addr) * 15'd9 + 15'(j)] <= ld_data[j]; // RULE9
      end
    end
    for (int q = 0; q < 2; q++) begin
      for (int i = 0; i < 36; i++) begin
        if (wr_go[q] && 6'(i) < pbits[q] && (pw[q] < bram_pkg::WID_18 || be_q[q][i/9])) begin
          mem[phys(pw[q], addr_q[q], 6'(i))] <= wd_q[q][i]; // RULE6 RULE7 RULE16
        end
      end
    end
  end

  // Run state and configuration error
  always_ff @(posedge clock) begin
    if (!rstn) begin
      run_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      run_q <= run_q || user_start; // RULE9
      err_q <= (!legal[0] || rbw_bad[0]) || (active[1] && (!legal[1] || rbw_bad[1])); // RULE3 RULE15
    end
  end

  assign a_rdata  = dout_q[0];
  assign b_rdata  = dout_q[1];
  assign user_run = run_q;
  assign cfg_err  = err_q;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  in_capture_a: assert property (a_ce && run_q && legal[0] |=> req_q[0] && addr_q[0] == $past(a_addr)) // RULE11
    else $error("port A input not captured");
  thru_out_a: assert property (wr_go[0] && wm_eff[0] == bram_pkg::WM_THRU && !a_oreg && pw[0] == bram_pkg::WID_36 // RULE14
                               |=> a_rdata == $past(wd_q[0]))
    else $error("write-through data missing");
  thru_x9_a: assert property (wr_go[0] && wm_eff[0] == bram_pkg::WM_THRU && !a_oreg && pw[0] == bram_pkg::WID_9 // RULE14
                              |=> a_rdata == {27'h0000000, $past(wd_q[0][8:0])})
    else $error("write-through x9 data missing");
  norm_hold_a: assert property (wr_go[0] && wm_eff[0] == bram_pkg::WM_NORMAL && !a_oreg |=> $stable(a_rdata)) // RULE13
    else $error("normal write changed output");
  rbw_old_a: assert property (wr_go[0] && pwm[0] == bram_pkg::WM_RBW && pw[0] >= bram_pkg::WID_9 && !a_oreg // RULE15
                              |=> a_rdata == $past(rd_word[0]))
    else $error("read-before-write lost old data");
  oreg_lat_b: assert property (b_oreg && b_oce && $stable(b_oreg) |=> b_rdata == $past(arr_q[1])) // RULE12
    else $error("output register stage wrong");
  rom_no_write_a: assert property (is_rom |-> ##1 !wr_go[0] && !wr_go[1]) // RULE10
    else $error("write in ROM mode");
  tdp_wide_err_a: assert property (is_tdp && (a_width == bram_pkg::WID_36) |=> cfg_err && !req_q[0]) // RULE3
    else $error("x36 accepted in true dual-port");
  load_gate_a: assert property (run_q |-> !ld_go ##1 run_q) // RULE9
    else $error("preload after start");
  pdp_roles_a: assert property (is_pdp && $stable(mode) |=> !wr_go[1]) // RULE7
    else $error("port B wrote in pseudo dual-port");
  oreg_lat_a: assert property (a_oreg && a_oce && $stable(a_oreg) |=> a_rdata == $past(arr_q[0])) // RULE12
    else $error("port A output register stage wrong");
  oce_hold_a: assert property (a_oreg && !a_oce |=> $stable(a_rdata)) // RULE2
    else $error("output register moved with enable low");

  thru_seen_c: cover property (wr_go[0] && wm_eff[0] == bram_pkg::WM_THRU);
  rbw_seen_c:  cover property (wr_go[1] && wm_eff[1] == bram_pkg::WM_RBW);
  dual_wr_c:   cover property (wr_go[0] && wr_go[1]);
  rom_read_c:  cover property (is_rom && req_q[0] ##2 req_q[0]);

endmodule : bram_core

`default_nettype wire

// >>> verif/bram_fab.sv
// Fabric user logic model driving the request side of both tile ports.
// Assumes one clock shared with the tile; slice 0 is port A, slice 1 port B.
`timescale 1ns/10ps
`default_nettype none

module bram_fab (
  // Clock
  input  wire logic        clock,
  // Requests, port B in the upper slice
  output logic      [1:0]  ce,
  output logic      [1:0]  we,
  output logic      [7:0]  be,
  output logic      [27:0] addr,
  output logic      [71:0] wdata
);
  initial begin
    ce = 2'h0;
    we = 2'h0;
    be = 8'h00;
    addr = 28'h0000000;
    wdata = 72'h000000000000000000;
  end

  // One access on one port; pointers and flags stay with the caller
  task op(input int p, input logic w, input logic [3:0] m, input logic [13:0] a, input logic [35:0] d);
    @(posedge clock);
    ce[p] <= 1'b1;
    we[p] <= w;
    be[4*p+:4] <= m;
    addr[14*p+:14] <= a;
    wdata[36*p+:36] <= d;
    @(posedge clock);
    ce[p] <= 1'b0;
    we[p] <= 1'b0;
    wdata[36*p+:36] <= ~d;
  endtask : op
endmodule : bram_fab

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the block RAM tile.
// Assumes the fabric model drives both ports on the shared clock.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic        clock = 1'b0, rstn = 1'b0, a_oreg = 1'b0, b_oreg = 1'b0, a_oce = 1'b1, b_oce = 1'b1;
  logic        user_start = 1'b0, ld_en = 1'b0, user_run, cfg_err;
  logic [1:0]  mode = 2'h0, a_wmode = 2'h0, b_wmode = 2'h0, ce, we;
  logic [2:0]  a_width = 3'h3, b_width = 3'h3;
  logic [10:0] ld_addr = 11'h000;
  logic [8:0]  ld_data = 9'h000;
  logic [7:0]  be;
  logic [27:0] addr;
  logic [71:0] wdata;
  logic [35:0] a_rdata, b_rdata;
  int          fails = 0, num_checks = 0, cycles = 0;

  bram_core i_bram_core (
    .clock, .rstn, .mode, .a_width, .b_width, .a_wmode, .b_wmode, .a_oreg, .b_oreg,
    .user_start, .ld_en, .ld_addr, .ld_data, .a_ce(ce[0]), .a_oce, .a_we(we[0]), .a_be(be[3:0]),
    .a_addr(addr[13:0]), .a_wdata(wdata[35:0]), .a_rdata, .b_ce(ce[1]), .b_oce, .b_we(we[1]),
    .b_be(be[7:4]), .b_addr(addr[27:14]), .b_wdata(wdata[71:36]), .b_rdata, .user_run, .cfg_err
  );
  bram_fab i_bram_fab (.clock, .ce, .we, .be, .addr, .wdata);

  always #5 clock = ~clock;

  task check(input string what, input logic [35:0] exp, input logic [35:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle

  task setup(input logic [1:0] m, input logic [2:0] w, input logic [1:0] wm, input logic r);
    @(posedge clock);
    mode <= m;
    a_width <= w;
    a_wmode <= wm;
    a_oreg <= r;
  endtask : setup

  task t_rom;
    @(posedge clock);
    ld_en <= 1'b1;
    ld_data <= 9'h1A5;
    @(posedge clock);
    ld_addr <= 11'h001;
    ld_data <= 9'h0C3;
    @(posedge clock);
    ld_en <= 1'b0;
    user_start <= 1'b1;
    setup(2'h3, 3'h4, 2'h0, 1'b0);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0000, 36'h000000000);
    settle(1);
    check("rom word", {18'h00000, 9'h0C3, 9'h1A5}, a_rdata);
    @(posedge clock);
    ld_en <= 1'b1;
    ld_addr <= 11'h000;
    ld_data <= 9'h0FF;
    @(posedge clock);
    ld_en <= 1'b0;
    i_bram_fab.op(0, 1'b1, 4'hF, 14'h0000, 36'h00003FFFF);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0000, 36'h000000000);
    settle(1);
    check("rom kept", {18'h00000, 9'h0C3, 9'h1A5}, a_rdata);
  endtask : t_rom

  task t_wide;
    setup(2'h0, 3'h5, 2'h0, 1'b0);
    i_bram_fab.op(0, 1'b1, 4'hF, 14'h0009, 36'h123456789);
    i_bram_fab.op(0, 1'b1, 4'h4, 14'h0009, 36'hFEDCBA987);
    settle(1);
    check("normal write", {18'h00000, 9'h0C3, 9'h1A5}, a_rdata);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0009, 36'h000000000);
    settle(1);
    check("byte enable", (36'h123456789 & 36'hFF803FFFF) | (36'hFEDCBA987 & 36'h007FC0000), a_rdata);
  endtask : t_wide

  task t_modes;
    setup(2'h0, 3'h3, 2'h1, 1'b0);
    i_bram_fab.op(0, 1'b1, 4'h0, 14'h0005, 36'h0000001F0);
    settle(1);
    check("write through", 36'h0000001F0, a_rdata);
    setup(2'h0, 3'h3, 2'h2, 1'b0);
    i_bram_fab.op(0, 1'b1, 4'h0, 14'h0005, 36'h000ABC10F);
    settle(1);
    check("read before write", 36'h0000001F0, a_rdata);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0005, 36'h000000000);
    settle(1);
    check("x9 read", 36'h00000010F, a_rdata);
  endtask : t_modes

  task t_bus;
    setup(2'h2, 3'h4, 2'h0, 1'b0);
    i_bram_fab.op(0, 1'b1, 4'h3, 14'h0003, 36'h00002A5C3);
    i_bram_fab.op(1, 1'b0, 4'h0, 14'h0006, 36'h000000000);
    settle(1);
    check("b low unit", 36'h0000001C3, b_rdata);
    i_bram_fab.op(1, 1'b1, 4'h0, 14'h0006, 36'h0000000AA);
    i_bram_fab.op(1, 1'b0, 4'h0, 14'h0006, 36'h000000000);
    settle(1);
    check("b write refused", 36'h0000001C3, b_rdata);
    i_bram_fab.op(1, 1'b0, 4'h0, 14'h0007, 36'h000000000);
    settle(1);
    check("b high unit", 36'h000000152, b_rdata);
  endtask : t_bus

  task t_oreg;
    setup(2'h0, 3'h3, 2'h0, 1'b1);
    i_bram_fab.op(0, 1'b1, 4'h0, 14'h0006, 36'h000000155);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0006, 36'h000000000);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0005, 36'h000000000);
    settle(1);
    check("oreg delay", 36'h000000155, a_rdata);
    settle(1);
    check("oreg next", 36'h00000010F, a_rdata);
    @(posedge clock);
    a_oce <= 1'b0;
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0006, 36'h000000000);
    settle(3);
    check("oreg held", 36'h00000010F, a_rdata);
    @(posedge clock);
    a_oce <= 1'b1;
  endtask : t_oreg

  task t_dual;
    setup(2'h1, 3'h4, 2'h0, 1'b0);
    b_wmode <= 2'h2;
    i_bram_fab.op(1, 1'b1, 4'h0, 14'h0006, 36'h0000000AA);
    settle(1);
    check("b old word", 36'h000000155, b_rdata);
    i_bram_fab.op(0, 1'b0, 4'h0, 14'h0003, 36'h000000000);
    settle(1);
    check("a sees b write", {18'h00000, 9'h152, 9'h0AA}, a_rdata);
  endtask : t_dual

  task t_cfg;
    setup(2'h1, 3'h5, 2'h0, 1'b0);
    settle(2);
    check("x36 dual port", 36'h000000001, {35'h0, cfg_err});
    setup(2'h0, 3'h0, 2'h2, 1'b0);
    settle(2);
    check("rbw at x1", 36'h000000001, {35'h0, cfg_err});
    setup(2'h1, 3'h4, 2'h0, 1'b0);
    settle(2);
    check("x18 dual port", 36'h000000000, {35'h0, cfg_err});
  endtask : t_cfg

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    settle(0);
    check("reset rdata", 36'h000000000, a_rdata);
    check("reset b rdata", 36'h000000000, b_rdata);
    check("reset run", 36'h000000000, {35'h0, user_run});
    check("reset err", 36'h000000000, {35'h0, cfg_err});
    t_rom();
    t_wide();
    t_modes();
    t_bus();
    t_oreg();
    t_dual();
    t_cfg();
    stop_test();
  end
endmodule : testbench

`default_nettype wire
